// File: design/pmm_pkg.sv
// Package with constants for the program memory map block
package pmm_pkg;
  localparam int          PMM_PC_W        = 13;
  localparam int          PMM_ARR_AW      = 12;
  localparam int          PMM_WORD_W      = 14;
  localparam int          PMM_ARR_DEPTH   = 4096;
  localparam logic [12:0] PMM_RESET_VEC   = 13'h0000;
  localparam logic [12:0] PMM_INT_VEC     = 13'h0004;
  localparam logic [15:0] PMM_CAL_HALF    = 16'h2088;
  localparam logic [15:0] PMM_CAL_GAIN    = 16'h208B;
  localparam int          PMM_GAIN_W      = 8;
  localparam int          PMM_HALF_W      = 10;
  localparam logic [7:0]  PMM_PROG_SEL_BIT = 8'h80;
  // AXI4-Lite register byte offsets
  localparam logic [7:0]  PMM_R_CTRL      = 8'h00;
  localparam logic [7:0]  PMM_R_PC        = 8'h04;
  localparam logic [7:0]  PMM_R_PTR       = 8'h08;
  localparam logic [7:0]  PMM_R_WDATA     = 8'h0C;
  localparam logic [7:0]  PMM_R_CMD       = 8'h10;
  localparam logic [7:0]  PMM_R_ACC       = 8'h14;
  localparam logic [7:0]  PMM_R_INSTR     = 8'h18;
  localparam logic [7:0]  PMM_R_STAT      = 8'h1C;
  localparam logic [7:0]  PMM_R_CAL_GAIN  = 8'h20;
  localparam logic [7:0]  PMM_R_CAL_HALF  = 8'h24;
  localparam logic [7:0]  PMM_R_LOAD_ADR  = 8'h28;
  localparam logic [7:0]  PMM_R_LOAD_DAT  = 8'h2C;
  localparam logic [1:0]  PMM_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  PMM_RESP_SLVERR = 2'b10;
  localparam logic [7:0]  PMM_GAIN_DEF    = 8'hFF;
  localparam logic [9:0]  PMM_HALF_DEF    = 10'h3FF;
  localparam int          PMM_DATA_CYC    = 1;
  localparam int          PMM_PROG_CYC    = 2;
  typedef enum logic [1:0] {
    PMM_IDLE  = 2'b00,
    PMM_EXEC  = 2'b01,
    PMM_EXTRA = 2'b10
  } pmm_state_t;
endpackage

// File: design/pmm_array.sv
// Program memory array with one write port and one read port
`timescale 1ns/100ps
`default_nettype none
module pmm_array
  import pmm_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_we,
  input  wire logic [PMM_ARR_AW-1:0] i_waddr,
  input  wire logic [PMM_WORD_W-1:0] i_wdata,
  input  wire logic [PMM_ARR_AW-1:0] i_raddr,
  output logic      [PMM_WORD_W-1:0] o_rdata
);
  logic [PMM_WORD_W-1:0] mem [PMM_ARR_DEPTH];
  logic [PMM_WORD_W-1:0] rdata_q;

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    rdata_q <= mem[i_raddr];
  end
  assign o_rdata = rdata_q;
endmodule
`default_nettype wire

// File: design/pmm_top.sv
// Program memory map with fetch, indirect data read and calibration words
// Notes on behaviour
// - Gain error trim is read-only 8 bits at 208Bh, bits 13-8 zero.
// - Half supply count is read-only 10 bits at 2088h, bits 13-10 zero.
// - The 13-bit program counter spans 8192 words of 14 bits.
// - Only 0000h-0FFFh exists and higher addresses wrap into it.
// - Reset starts at 0000h and an interrupt jumps to 0004h.
// - The instruction bus is 14 bits and each instruction is one word.
// - Pointer high byte bit 7 set makes the port target program memory.
// - An indirect move from program memory loads only the low 8 bits.
// - Indirect writes that point at program memory change nothing.
// - Indirect program memory reads take one extra instruction cycle.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pmm_top
  import pmm_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [13:0]      o_instr
);
  // Command: bit0 fetch step, bit1 interrupt, bit2 indirect read, bit3 write
  logic [12:0] pc_q, pc_d;
  logic [15:0] ptr_q, ptr_d;
  logic [7:0]  wd_q, wd_d;
  logic [7:0]  acc_q, acc_d;
  logic [13:0] instr_q, instr_d;
  logic [7:0]  dmem_q [256];
  logic [7:0]  dmem_wdat;
  logic        dmem_we;
  logic [7:0]  dmem_wadr;
  logic [11:0] load_adr_q, load_adr_d;
  logic        load_we;
  logic [7:0]  gain_q, gain_d;
  logic [9:0]  half_q, half_d;
  logic [1:0]  cyc_q, cyc_d;
  logic        ign_q, ign_d;
  pmm_state_t  st_q, st_d;
  logic        fetch_pend_q, fetch_pend_d;
  logic [11:0] raddr;
  logic [13:0] arr_rdata;
  // Bus slave state
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wdt_q, wdt_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        prog_sel;
  // Strobe travels with its data beat, not with the later commit
  logic        ws_q, ws_d;
  // Ready flops mirror the next holding state so outputs leave flops
  logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;

  assign wr_go = aw_q && w_q && !bv_q;
  assign rd_go = i_arvalid && !rv_q;

  // Bit 7 of the pointer high byte picks program memory
  assign prog_sel = (ptr_q[15:8] & PMM_PROG_SEL_BIT) != 8'h00;

  // Wrap by discarding bit 12 of the address
  assign raddr = (st_q == PMM_IDLE) ? pc_q[11:0]
                                    : ptr_q[11:0];

  pmm_array u_pmm_array (
    .i_clk   (i_clk),
    .i_we    (load_we),
    .i_waddr (load_adr_q),
    .i_wdata (wdt_q[13:0]),
    .i_raddr (raddr),
    .o_rdata (arr_rdata)
  );

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    case (i_araddr)
      PMM_R_PC:       rd_val = {19'h00000, pc_q};
      PMM_R_PTR:      rd_val = {16'h0000, ptr_q};
      PMM_R_WDATA:    rd_val = {24'h000000, wd_q};
      PMM_R_CTRL:     rd_val = 32'h0000_0000;
      PMM_R_CMD:      rd_val = 32'h0000_0000;
      PMM_R_ACC:      rd_val = {24'h000000, acc_q};
      PMM_R_INSTR:    rd_val = {18'h00000, instr_q};
      PMM_R_STAT:     rd_val = {28'h0000000, ign_q, cyc_q, st_q != PMM_IDLE};
      PMM_R_CAL_GAIN: rd_val = {24'h000000, gain_q};
      PMM_R_CAL_HALF: rd_val = {22'h000000, half_q};
      PMM_R_LOAD_ADR: rd_val = {20'h00000, load_adr_q};
      PMM_R_LOAD_DAT: rd_val = 32'h0000_0000;
      default:        rd_ok  = 1'b0;
    endcase
  end

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    bv_d = bv_q;
    rv_d = rv_q;
    awa_d = awa_q;
    wdt_d = wdt_q;
    br_d = br_q;
    rr_d = rr_q;
    rd_d = rd_q;
    ws_d = ws_q;
    if (i_awvalid && !aw_q && !bv_q) begin
      aw_d  = 1'b1;
      awa_d = i_awaddr;
    end
    if (i_wvalid && !w_q && !bv_q) begin
      w_d   = 1'b1;
      wdt_d = i_wdata;
      ws_d  = i_wstrb[0];
    end
    if (wr_go) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = (awa_q > PMM_R_LOAD_DAT || awa_q[1:0] != 2'b00)
             ? PMM_RESP_SLVERR : PMM_RESP_OKAY;
    end
    if (bv_q && i_bready) begin
      bv_d = 1'b0;
    end
    if (rd_go) begin
      rv_d = 1'b1;
      rd_d = rd_val;
      rr_d = rd_ok ? PMM_RESP_OKAY : PMM_RESP_SLVERR;
    end
    if (rv_q && i_rready) begin
      rv_d = 1'b0;
    end
    // Same value the slot flags give one cycle later, without a comb path
    awrdy_d = !aw_d && !bv_d;
    wrdy_d  = !w_d && !bv_d;
    arrdy_d = !rv_d;
  end

  always_comb begin
    pc_d = pc_q;
    ptr_d = ptr_q;
    wd_d = wd_q;
    acc_d = acc_q;
    instr_d = instr_q;
    load_adr_d = load_adr_q;
    load_we = 1'b0;
    gain_d = gain_q;
    half_d = half_q;
    cyc_d = cyc_q;
    ign_d = ign_q;
    st_d = st_q;
    fetch_pend_d = 1'b0;
    dmem_we = 1'b0;
    dmem_wadr = ptr_q[7:0];
    dmem_wdat = wd_q;
    // A word with its low strobe clear is answered but changes nothing
    if (wr_go && ws_q) begin
      case (awa_q)
        PMM_R_PC:       pc_d = wdt_q[12:0];
        PMM_R_PTR:      ptr_d = wdt_q[15:0];
        PMM_R_WDATA:    wd_d = wdt_q[7:0];
        PMM_R_LOAD_ADR: load_adr_d = wdt_q[11:0];
        PMM_R_LOAD_DAT: load_we = 1'b1;
        PMM_R_CMD: begin
          // Fetch and read are only taken when idle so a pending result is never lost
          if (wdt_q[1]) begin
            pc_d = PMM_INT_VEC;
          end else if (wdt_q[0] && st_q == PMM_IDLE) begin
            fetch_pend_d = 1'b1;
            pc_d = 13'(pc_q + 13'h0001);
          end
          if (wdt_q[2] && st_q == PMM_IDLE) begin
            st_d  = PMM_EXEC;
            cyc_d = 2'h1;
          end
          if (wdt_q[3]) begin
            // Program targets are dropped, never written
            if (prog_sel) begin
              ign_d = 1'b1;
            end else begin
              dmem_we = 1'b1;
            end
          end
        end
        PMM_R_CAL_GAIN: gain_d = gain_q;
        default: ign_d = ign_q;
      endcase
    end
    if (fetch_pend_q) begin
      instr_d = arr_rdata;
    end
    case (st_q)
      PMM_IDLE: st_d = st_d;
      PMM_EXEC: begin
        if (prog_sel) begin
          st_d  = PMM_EXTRA;
          cyc_d = 2'(PMM_PROG_CYC);
        end else begin
          acc_d = dmem_q[ptr_q[7:0]];
          st_d  = PMM_IDLE;
        end
      end
      PMM_EXTRA: begin
        acc_d = arr_rdata[7:0];
        st_d  = PMM_IDLE;
      end
      default: st_d = PMM_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (dmem_we) begin
      dmem_q[dmem_wadr] <= dmem_wdat;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pc_q <= PMM_RESET_VEC;
      ptr_q <= 16'h0000;
      wd_q <= 8'h00;
      acc_q <= 8'h00;
      instr_q <= 14'h0000;
      load_adr_q <= 12'h000;
      gain_q <= PMM_GAIN_DEF;
      half_q <= PMM_HALF_DEF;
      cyc_q <= 2'h0;
      ign_q <= 1'b0;
      st_q <= PMM_IDLE;
      fetch_pend_q <= 1'b0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      awa_q <= 8'h00;
      wdt_q <= 32'h0000_0000;
      br_q <= PMM_RESP_OKAY;
      rr_q <= PMM_RESP_OKAY;
      rd_q <= 32'h0000_0000;
      ws_q <= 1'b0;
      awrdy_q <= 1'b1;
      wrdy_q <= 1'b1;
      arrdy_q <= 1'b1;
    end else begin
      pc_q <= pc_d;
      ptr_q <= ptr_d;
      wd_q <= wd_d;
      acc_q <= acc_d;
      instr_q <= instr_d;
      load_adr_q <= load_adr_d;
      gain_q <= gain_d;
      half_q <= half_d;
      cyc_q <= cyc_d;
      ign_q <= ign_d;
      st_q <= st_d;
      fetch_pend_q <= fetch_pend_d;
      aw_q <= aw_d;
      w_q <= w_d;
      bv_q <= bv_d;
      rv_q <= rv_d;
      awa_q <= awa_d;
      wdt_q <= wdt_d;
      br_q <= br_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
      ws_q <= ws_d;
      awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d;
      arrdy_q <= arrdy_d;
    end
  end

  // Ready only while the holding slot is empty
  assign o_awready = awrdy_q;
  assign o_wready  = wrdy_q;
  assign o_bvalid  = bv_q;
  assign o_bresp   = br_q;
  assign o_arready = arrdy_q;
  assign o_rvalid  = rv_q;
  assign o_rdata   = rd_q;
  assign o_rresp   = rr_q;
  assign o_instr   = instr_q;
endmodule
`default_nettype wire

// File: test/pmm_core_model.sv
// Behavioural processor core view of the program memory image
`timescale 1ns/100ps
`default_nettype none
module pmm_core_model;
  // Mirrors what the bench programmed into the array
  logic [13:0] img [0:4095];
  // Fetch view: bit 12 of the 13-bit address is dropped, so it aliases
  function automatic logic [13:0] word(input logic [12:0] a);
    return img[a[11:0]];
  endfunction
  // Constant as a return-with-literal table or an indirect move hands it
  function automatic logic [7:0] lit(input logic [12:0] a);
    return img[a[11:0]][7:0];
  endfunction
endmodule
`default_nettype wire

// File: test/pmm_top_sva.sv
// Concurrent checks on the program memory map register port
`timescale 1ns/100ps
`default_nettype none
module pmm_top_sva
  import pmm_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic [7:0]  i_araddr,
  input wire logic        i_arvalid,
  input wire logic        i_rready,
  input wire logic        i_bready,
  input wire logic        o_arready,
  input wire logic        o_awready,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_rvalid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence rd_at(logic [7:0] a);
    i_arvalid && o_arready && i_araddr == a;
  endsequence
  a_b_hold: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("write response dropped");
  a_r_hold: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("read data dropped");
  a_b_blocks: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
  a_r_latency: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  a_gain_width: assert property (
    rd_at(PMM_R_CAL_GAIN) |=> o_rdata[31:8] == 24'h0)
    else $error("gain trim upper bits set");
  a_half_width: assert property (
    rd_at(PMM_R_CAL_HALF) |=> o_rdata[31:10] == 22'h0)
    else $error("half supply upper bits set");
  a_pc_width: assert property (
    rd_at(PMM_R_PC) |=> o_rdata[31:13] == 19'h0)
    else $error("program counter wider than 13 bits");
  a_instr_width: assert property (
    rd_at(PMM_R_INSTR) |=> o_rdata[31:14] == 18'h0)
    else $error("instruction wider than 14 bits");
  a_acc_width: assert property (
    rd_at(PMM_R_ACC) |=> o_rdata[31:8] == 24'h0)
    else $error("accumulator wider than 8 bits");
  a_bad_addr: assert property (i_arvalid && o_arready &&
    i_araddr > 8'h2C |=> o_rresp == PMM_RESP_SLVERR && o_rdata == 32'h0)
    else $error("unmapped read not refused");
  c_write: cover property (o_bvalid && i_bready);
  c_read: cover property (o_rvalid && i_rready);
  c_refuse: cover property (o_rvalid && o_rresp == PMM_RESP_SLVERR);
endmodule
bind pmm_top pmm_top_sva u_pmm_top_sva (.i_clk(i_clk), .i_reset(i_reset),
  .i_araddr(i_araddr), .i_arvalid(i_arvalid), .i_rready(i_rready),
  .i_bready(i_bready), .o_arready(o_arready), .o_awready(o_awready),
  .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
  .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid));
`default_nettype wire

// File: test/test_program_memory_map_and_data_read.sv
// Register-level bench for the program memory map block
`timescale 1ns/100ps
`default_nettype none
module test_program_memory_map_and_data_read
  import pmm_pkg::*;
;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, rrsp, brsp;
  logic [31:0] rdata, rdat;
  logic [13:0] instr;
  int          n_errors = 0;
  int          samples_checked = 0;
  always #10 i_clk = ~i_clk;
  pmm_top u_pmm_top (.i_clk(i_clk), .i_reset(i_reset), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_instr(instr));
  pmm_core_model u_pmm_core_model ();
  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ready is looked at mid-cycle so the release lands on the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bv;
    bv = 1'b0;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bv) begin
      @(negedge i_clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bv = bvalid;
      brsp = bresp;
      @(posedge i_clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ah, rv;
    rv = 1'b0;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rv) begin
      @(negedge i_clk);
      ah = arvalid && arready;
      rv = rvalid;
      rdat = rdata;
      rrsp = rresp;
      @(posedge i_clk);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, logic [31:0] e);
    rd(a);
    chk(nm, e, rdat);
  endtask
  // Polls busy with a bound; the watchdog covers a stuck engine
  task automatic run(input logic [31:0] c);
    wr(PMM_R_CMD, c);
    rd(PMM_R_STAT);
    for (int i = 0; i < 10 && rdat[0]; i++) rd(PMM_R_STAT);
  endtask
  task automatic load(input logic [11:0] a, input logic [13:0] d);
    wr(PMM_R_LOAD_ADR, {20'h0, a});
    wr(PMM_R_LOAD_DAT, {18'h0, d});
    u_pmm_core_model.img[a] = d;
  endtask
  task automatic fetch_chk(input logic [12:0] pc);
    logic [12:0] nx;
    nx = pc + 13'h1;
    run(32'h1);
    rc("instr", PMM_R_INSTR, {18'h0, u_pmm_core_model.word(pc)});
    chk("instr port", {18'h0, u_pmm_core_model.word(pc)}, {18'h0, instr});
    rc("pc next", PMM_R_PC, {19'h0, nx});
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    rc("pc reset", PMM_R_PC, 32'h0);
    rc("gain", PMM_R_CAL_GAIN, {24'h0, PMM_GAIN_DEF});
    rc("half", PMM_R_CAL_HALF, {22'h0, PMM_HALF_DEF});
    wr(PMM_R_CAL_GAIN, 32'h0);
    chk("gain wr resp", {30'h0, PMM_RESP_OKAY}, {30'h0, brsp});
    rc("gain ro", PMM_R_CAL_GAIN, {24'h0, PMM_GAIN_DEF});
    rd(8'h30);
    chk("bad addr", {30'h0, PMM_RESP_SLVERR}, {30'h0, rrsp});
    wr(8'h30, 32'h0);
    chk("bad wr resp", {30'h0, PMM_RESP_SLVERR}, {30'h0, brsp});
    wr(8'h06, 32'h0);
    chk("odd wr resp", {30'h0, PMM_RESP_SLVERR}, {30'h0, brsp});
    $display("register test done");
    load(12'h000, 14'h3ABC);
    load(12'h004, 14'h1234);
    load(12'h123, 14'h2F5A);
    load(12'hFFF, 14'h3FFF);
    fetch_chk(PMM_RESET_VEC);
    run(32'h2);
    rc("int vec", PMM_R_PC, {19'h0, PMM_INT_VEC});
    fetch_chk(PMM_INT_VEC);
    wr(PMM_R_PC, 32'h1123);
    fetch_chk(13'h1123);
    wr(PMM_R_PC, 32'h1FFF);
    fetch_chk(13'h1FFF);
    // A word whose low strobe is clear must leave the counter alone
    wstrb <= 4'h0;
    wr(PMM_R_PC, 32'h0ABC);
    wstrb <= 4'hF;
    rc("pc strobe", PMM_R_PC, 32'h0);
    $display("fetch test done");
    wr(PMM_R_PTR, 32'h0010);
    wr(PMM_R_WDATA, 32'h77);
    run(32'h8);
    run(32'h4);
    rc("acc data", PMM_R_ACC, 32'h77);
    rc("data cyc", PMM_R_STAT, 32'(PMM_DATA_CYC) << 1);
    wr(PMM_R_PTR, 32'h9123);
    run(32'h4);
    rc("acc prog", PMM_R_ACC,
       {24'h0, u_pmm_core_model.lit(13'h0123)});
    rc("prog cyc", PMM_R_STAT, 32'(PMM_PROG_CYC) << 1);
    wr(PMM_R_WDATA, 32'h00);
    run(32'h8);
    chk("ignored", 32'h1, {31'h0, rdat[3]});
    run(32'h4);
    rc("acc kept", PMM_R_ACC,
       {24'h0, u_pmm_core_model.lit(13'h0123)});
    $display("indirect test done");
    end_of_test();
  end
endmodule
`default_nettype wire
